/* File: hw/dac_latch_pkg.sv */
// Functional notes
// - START then address write, device acknowledges address
// - Acknowledge pointer only when bits 4:3 are zero
// - Value sent high byte first, bits 9:8 then 7:0
// - Store channel only after second byte received
// - Acknowledge every written data byte
// - STOP or START mid-pair discards partial value
// - Pointer advances after each byte pair until it passes channel 7
// - Burst from channel zero stores eighth after data byte 16
// - Early end updates only fully received channels
// - Read: pointer write, restart, address read, acknowledged
// - Read returns high byte then low byte
// - Read pointer steps after each channel pair
// - Read ends on STOP, START or missing acknowledge
// - Separate storage and output registers per channel
// - Latch pin low: output follows storage update
// - Latch pin high holds; falling edge copies all
// - Bit 15 set copies all after second byte
// - General call and power-up reset load outputs
// - Bus address 111010 plus address select pin
// - General call acknowledged; data 06h does full reset
// - Pointer top bits 100 all mid, 010 one mid
// - Power-up reset sets every output mid-scale
package dac_latch_pkg;
  localparam int          NUM_CH      = 8;
  localparam int          VAL_W       = 10;
  localparam logic [5:0]  DEV_ADDR_HI = 6'h3a;
  localparam logic [6:0]  GCALL_ADDR  = 7'h00;
  localparam logic [7:0]  GCALL_RESET = 8'h06;
  localparam logic [9:0]  MID_SCALE   = 10'h200;
  localparam logic [2:0]  CMD_ALL_MID = 3'h4;
  localparam logic [2:0]  CMD_ONE_MID = 3'h2;
  localparam int          COPY_BIT    = 7;
  typedef logic [VAL_W-1:0] ch_val_t;
endpackage : dac_latch_pkg

/* File: hw/bus_cond_detect.sv */
`timescale 1ns/1ns
// Synchronises the two bus pins and finds clock edges, START and STOP
module bus_cond_detect (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det,
  output logic      sda_s
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  assign sda_s     = sda_d_reg;
  assign scl_rise  = scl_sync_reg[1] & ~scl_d_reg;
  assign scl_fall  = ~scl_sync_reg[1] & scl_d_reg;
  assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
  assign stop_det  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
endmodule : bus_cond_detect

/* File: hw/dac_channel_i2c_slave_latch.sv */
`timescale 1ns/1ns
module dac_channel_i2c_slave_latch
  import dac_latch_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  input  wire logic                 address_select_pin,
  input  wire logic                 output_latch_pin,
  output dac_latch_pkg::ch_val_t    dac_out [dac_latch_pkg::NUM_CH]
);
  import dac_latch_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_PTR  = 6'h04,
    ST_WDAT = 6'h08,
    ST_RDAT = 6'h10,
    ST_GC   = 6'h20
  } state_t;

  logic    scl_rise;
  logic    scl_fall;
  logic    start_det;
  logic    stop_det;
  logic    sda_s;
  logic    [1:0] lat_sync_reg;
  logic    lat_d_reg;
  logic    lat_fall;

  state_t  state_reg;
  logic    [3:0] bit_cnt_reg;
  logic    [7:0] shift_reg;
  logic    ack_phase_reg;
  logic    ack_drive_reg;
  logic    rd_drive_reg;
  logic    [3:0] ptr_reg;
  logic    second_reg;
  logic    [7:0] hi_byte_reg;
  logic    one_mid_reg;
  logic    addr_ok_reg;
  ch_val_t store_reg [NUM_CH];
  ch_val_t out_reg   [NUM_CH];
  logic    [7:0] tx_reg;
  logic    soft_reset;
  logic    pair_done;
  logic    copy_all;
  logic    copy_pend_reg;
  logic    all_mid;
  logic    [7:0] rx_byte;

  ////////////////////////////////////////////////////////////////////////////
  bus_cond_detect u_cond (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_s     (sda_s)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lat_sync_reg <= 2'h3;
      lat_d_reg    <= 1'b1;
    end else begin
      lat_sync_reg <= {lat_sync_reg[0], output_latch_pin};
      lat_d_reg    <= lat_sync_reg[1];
    end
  end
  assign lat_fall = lat_d_reg & ~lat_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Byte shifter: eight data bits sampled on SCL rise, ninth is acknowledge
  assign rx_byte = {shift_reg[6:0], sda_s};

  always_ff @(posedge clk_sys) begin
    if (!resetn || start_det || stop_det) begin
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
    end else if (scl_rise && (state_reg != ST_IDLE || bit_cnt_reg == 4'h8)) begin
      if (bit_cnt_reg == 4'h8) begin
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg   <= rx_byte;
        if (bit_cnt_reg == 4'h7) begin
          ack_phase_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state, pointer and write assembly
  logic byte_done;
  assign byte_done = scl_rise && bit_cnt_reg == 4'h7;

  always_ff @(posedge clk_sys) begin
    if (!resetn || soft_reset) begin
      state_reg   <= ST_IDLE;
      ptr_reg     <= 4'h0;
      second_reg  <= 1'b0;
      hi_byte_reg <= 8'h00;
      one_mid_reg <= 1'b0;
    end else if (start_det) begin
      state_reg  <= ST_ADDR;
      second_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= ST_IDLE;
      second_reg <= 1'b0;
    end else if (byte_done) begin
      case (state_reg)
        ST_ADDR: begin
          if (rx_byte[7:1] == {DEV_ADDR_HI, address_select_pin}) begin
            state_reg <= rx_byte[0] ? ST_RDAT : ST_PTR;
          end else if (rx_byte[7:1] == GCALL_ADDR && !rx_byte[0]) begin
            state_reg <= ST_GC;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_PTR: begin
          if (rx_byte[4:3] == 2'h0) begin
            ptr_reg     <= {1'b0, rx_byte[2:0]};
            one_mid_reg <= rx_byte[7:5] == CMD_ONE_MID;
            state_reg   <= ST_WDAT;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WDAT: begin
          if (!second_reg) begin
            hi_byte_reg <= rx_byte;
            second_reg  <= 1'b1;
          end else begin
            second_reg <= 1'b0;
            if (!ptr_reg[3]) begin
              ptr_reg <= ptr_reg + 4'h1;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (scl_rise && bit_cnt_reg == 4'h8 && state_reg == ST_RDAT && !ack_drive_reg) begin
      if (sda_s) begin
        state_reg <= ST_IDLE;
      end else if (second_reg) begin
        second_reg <= 1'b0;
        ptr_reg    <= ptr_reg + 4'h1;
      end else begin
        second_reg <= 1'b1;
      end
    end
  end

  assign pair_done = byte_done && state_reg == ST_WDAT && second_reg && !ptr_reg[3];
  assign copy_all  = pair_done && hi_byte_reg[COPY_BIT];
  assign all_mid   = byte_done && state_reg == ST_PTR && rx_byte[4:3] == 2'h0
                     && rx_byte[7:5] == CMD_ALL_MID;
  assign soft_reset = byte_done && state_reg == ST_GC && rx_byte == GCALL_RESET;

  // Acknowledge decision per byte; kept apart so a general call reset still acks
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_ok_reg <= 1'b0;
    end else if (byte_done) begin
      addr_ok_reg <= (state_reg == ST_ADDR && (rx_byte[7:1] == {DEV_ADDR_HI, address_select_pin}
                      || (rx_byte[7:1] == GCALL_ADDR && !rx_byte[0])))
                     || (state_reg == ST_PTR && rx_byte[4:3] == 2'h0)
                     || state_reg == ST_WDAT
                     || (state_reg == ST_GC && rx_byte == GCALL_RESET);
    end
  end

  // Soft copy waits one cycle so the value just stored is included
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      copy_pend_reg <= 1'b0;
    end else begin
      copy_pend_reg <= copy_all;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and output registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      always_ff @(posedge clk_sys) begin
        if (!resetn || soft_reset || all_mid) begin
          store_reg[gi] <= MID_SCALE;
          out_reg[gi]   <= MID_SCALE;
        end else begin
          if (pair_done && ptr_reg[2:0] == 3'(gi)) begin
            store_reg[gi] <= one_mid_reg ? MID_SCALE : {hi_byte_reg[1:0], rx_byte};
          end
          if (!lat_sync_reg[1] || lat_fall || copy_pend_reg) begin
            out_reg[gi] <= store_reg[gi];
          end
        end
      end
      assign dac_out[gi] = out_reg[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive: acknowledge and read data change on SCL fall
  always_comb begin
    tx_reg = ptr_reg[3] ? 8'h00 : (second_reg ? store_reg[ptr_reg[2:0]][7:0]
             : {6'h00, store_reg[ptr_reg[2:0]][9:8]});
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || start_det || stop_det) begin
      ack_drive_reg <= 1'b0;
      rd_drive_reg  <= 1'b0;
      sda_out       <= 1'b1;
    end else if (scl_fall) begin
      ack_drive_reg <= 1'b0;
      rd_drive_reg  <= 1'b0;
      sda_out       <= 1'b1;
      if (ack_phase_reg && addr_ok_reg) begin
        ack_drive_reg <= 1'b1;
        sda_out       <= 1'b0;
      end else if (state_reg == ST_RDAT && bit_cnt_reg != 4'h8 && !ack_phase_reg) begin
        rd_drive_reg <= 1'b1;
        sda_out      <= tx_reg[3'(7 - bit_cnt_reg)];
      end
    end
  end
  assign sda_oe = ack_drive_reg | (rd_drive_reg & ~sda_out);

  ////////////////////////////////////////////////////////////////////////////
  a_pair_stores: assert property (@(posedge clk_sys) disable iff (!resetn)
    pair_done && !one_mid_reg |=> store_reg[$past(ptr_reg[2:0])] == $past({hi_byte_reg[1:0], rx_byte}))
    else $error("channel value not stored");
  a_ptr_steps: assert property (@(posedge clk_sys) disable iff (!resetn)
    pair_done && !soft_reset |=> ptr_reg == $past(ptr_reg) + 4'h1)
    else $error("pointer did not advance");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    lat_sync_reg[1] && $past(lat_sync_reg[1]) && !copy_pend_reg && !all_mid && !soft_reset
    |=> $stable(out_reg[0]))
    else $error("output moved while latched");
  a_latch_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    !lat_sync_reg[1] && !all_mid && !soft_reset |=> out_reg[0] == $past(store_reg[0]))
    else $error("output not following store");
  a_copy_all: assert property (@(posedge clk_sys) disable iff (!resetn)
    copy_pend_reg && !all_mid && !soft_reset |=> out_reg[7] == $past(store_reg[7]))
    else $error("soft copy missed");
  a_gc_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    soft_reset |=> out_reg[3] == MID_SCALE && state_reg == ST_IDLE)
    else $error("general call reset missed");
  a_abort_pair: assert property (@(posedge clk_sys) disable iff (!resetn)
    (start_det || stop_det) |=> !second_reg)
    else $error("partial pair kept");
  a_bad_ptr: assert property (@(posedge clk_sys) disable iff (!resetn)
    byte_done && state_reg == ST_PTR && rx_byte[4:3] != 2'h0 |=> state_reg == ST_IDLE)
    else $error("bad pointer accepted");
  a_nack_ends: assert property (@(posedge clk_sys) disable iff (!resetn)
    scl_rise && bit_cnt_reg == 4'h8 && state_reg == ST_RDAT && sda_s && !ack_drive_reg && !start_det
    && !stop_det |=> state_reg == ST_IDLE)
    else $error("read not ended");

  c_write: cover property (@(posedge clk_sys) pair_done);
  c_read: cover property (@(posedge clk_sys) state_reg == ST_RDAT && scl_fall);
  c_copy: cover property (@(posedge clk_sys) copy_all);
  c_gcall: cover property (@(posedge clk_sys) soft_reset);
endmodule : dac_channel_i2c_slave_latch

/* File: bench/i2c_master_model.sv */
`timescale 1ns/1ns
// Bus master: SCL half period of 6 clk_sys cycles, line idles high between frames
module i2c_master_model (
  input  wire logic clk_sys,
  input  wire logic sda_in_line,
  output logic      scl,
  output logic      sda_drv_low
);
  initial begin
    scl = 1'b1;
    sda_drv_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic start();
    sda_drv_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_drv_low = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(3);
  endtask : start
  task automatic stop();
    sda_drv_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_drv_low = 1'b0;
    tick(6);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_drv_low = ~b;
    tick(3);
    scl = 1'b1;
    tick(3);
    r = sda_in_line;
    tick(3);
    scl = 1'b0;
    tick(3);
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask : rbyte
endmodule : i2c_master_model

/* File: bench/dac_channel_i2c_slave_latch_tb.sv */
`timescale 1ns/1ns
module dac_channel_i2c_slave_latch_tb;
  import dac_latch_pkg::*;
  logic       clk_sys = 1'b0;
  logic       resetn  = 1'b0;
  logic       a_sel   = 1'b0;
  logic       latch   = 1'b0;
  logic       scl, m_low, sda_out, sda_oe, ack;
  logic [7:0] rb;
  wire        sda_line = ~m_low & ~(sda_oe & ~sda_out);
  ch_val_t    dac_out [NUM_CH];
  ch_val_t    model   [NUM_CH];
  int         errors = 0;
  int         n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  dac_channel_i2c_slave_latch u_dut (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(a_sel),
    .output_latch_pin(latch), .dac_out(dac_out));
  i2c_master_model u_master (.clk_sys(clk_sys), .sda_in_line(sda_line), .scl(scl),
    .sda_drv_low(m_low));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic ch_val_t bv(int i);
    return ch_val_t'(10'h0c3 + 10'h07d * i);
  endfunction : bv
  task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk
  task automatic chk_all(string what);
    for (int i = 0; i < NUM_CH; i++) chk(what, model[i], dac_out[i]);
    $display("test %s done", what);
  endtask : chk_all
  task automatic send(logic [7:0] b, logic exp_ack);
    u_master.wbyte(b, ack);
    chk("ack", {9'h0, exp_ack}, {9'h0, ack});
  endtask : send
  task automatic open_w(logic [7:0] ptr, logic ptr_ack);
    u_master.start();
    send(8'he8, 1'b1);
    send(ptr, ptr_ack);
  endtask : open_w
  task automatic pair(ch_val_t v, logic copy);
    send({copy, 5'h00, v[9:8]}, 1'b1);
    send(v[7:0], 1'b1);
  endtask : pair
  task automatic wait_ch(int c, ch_val_t e);
    int n;
    for (n = 0; n < 40 && dac_out[c] !== e; n++) @(negedge clk_sys);
    if (n == 40) begin
      $display("BAD wait_ch expected %h seen %h", e, dac_out[c]);
      errors++;
      conclude();
    end
  endtask : wait_ch
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_single();
    open_w(8'h03, 1'b1);
    pair(10'h155, 1'b0);
    u_master.stop();
    model[3] = 10'h155;
    chk_all("single");
  endtask : test_single
  task automatic test_gcall();
    latch = 1'b1;
    u_master.start();
    send(8'h00, 1'b1);
    send(8'h05, 1'b0);
    u_master.stop();
    u_master.start();
    send(8'h00, 1'b1);
    send(8'h06, 1'b1);
    u_master.stop();
    model[3] = MID_SCALE;
    wait_ch(3, MID_SCALE);
    chk_all("gcall");
    latch = 1'b0;
  endtask : test_gcall
  task automatic test_addr();
    a_sel = 1'b1;
    u_master.start();
    send(8'he8, 1'b0);
    u_master.stop();
    u_master.start();
    send(8'hea, 1'b1);
    send(8'h0f, 1'b0);
    u_master.stop();
    a_sel = 1'b0;
    chk("release", 10'h0, {9'h0, sda_oe});
    chk_all("addr");
  endtask : test_addr
  task automatic test_partial();
    open_w(8'h02, 1'b1);
    pair(10'h2aa, 1'b0);
    send(8'h01, 1'b1);
    u_master.stop();
    model[2] = 10'h2aa;
    chk_all("partial");
  endtask : test_partial
  task automatic test_burst();
    latch = 1'b1;
    open_w(8'h00, 1'b1);
    for (int i = 0; i < NUM_CH; i++) pair(bv(i), 1'b0);
    pair(10'h3ff, 1'b0);
    u_master.stop();
    chk_all("held");
    latch = 1'b0;
    wait_ch(7, bv(7));
    for (int i = 0; i < NUM_CH; i++) model[i] = bv(i);
    chk_all("burst");
  endtask : test_burst
  task automatic test_copy();
    latch = 1'b1;
    open_w(8'h04, 1'b1);
    pair(10'h111, 1'b0);
    chk("hold4", model[4], dac_out[4]);
    pair(10'h222, 1'b1);
    u_master.stop();
    model[4] = 10'h111;
    model[5] = 10'h222;
    chk_all("copy");
    latch = 1'b0;
  endtask : test_copy
  task automatic test_read();
    open_w(8'h05, 1'b1);
    u_master.start();
    send(8'he9, 1'b1);
    u_master.rbyte(1'b0, rb);
    chk("rd5hi", {8'h0, model[5][9:8]}, {8'h0, rb[1:0]});
    u_master.rbyte(1'b0, rb);
    chk("rd5lo", {2'h0, model[5][7:0]}, {2'h0, rb});
    u_master.rbyte(1'b0, rb);
    chk("rd6hi", {8'h0, model[6][9:8]}, {8'h0, rb[1:0]});
    u_master.rbyte(1'b1, rb);
    chk("rd6lo", {2'h0, model[6][7:0]}, {2'h0, rb});
    chk("rdrel", 10'h0, {9'h0, sda_oe});
    u_master.stop();
    $display("test read done");
  endtask : test_read
  task automatic test_cmds();
    open_w(8'h42, 1'b1);
    pair(10'h3ff, 1'b0);
    u_master.stop();
    model[2] = MID_SCALE;
    chk_all("one_mid");
    open_w(8'h80, 1'b1);
    u_master.stop();
    for (int i = 0; i < NUM_CH; i++) model[i] = MID_SCALE;
    chk_all("all_mid");
  endtask : test_cmds
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < NUM_CH; i++) model[i] = MID_SCALE;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    chk("oe_reset", 10'h0, {9'h0, sda_oe});
    chk_all("reset");
    u_master.tick(4);
    test_single();
    test_gcall();
    test_addr();
    test_partial();
    test_burst();
    test_copy();
    test_read();
    test_cmds();
    conclude();
  end
endmodule : dac_channel_i2c_slave_latch_tb
